// ### hw/iop_pkg.sv
package iop_pkg;

    // Register offsets
    localparam logic [4:0] OFS_P2_DIR = 5'h01;
    localparam logic [4:0] OFS_P1_DATA = 5'h02;
    localparam logic [4:0] OFS_P2_DATA = 5'h03;
    localparam logic [4:0] OFS_P3_DIR = 5'h04;
    localparam logic [4:0] OFS_P3_DATA = 5'h06;
    localparam logic [4:0] OFS_P4_DATA = 5'h07;
    localparam logic [4:0] OFS_CTRL = 5'h14;
    localparam logic [4:0] OFS_P5_IN = 5'h15;
    localparam logic [4:0] OFS_P6_DIR = 5'h16;
    localparam logic [4:0] OFS_P6_DATA = 5'h17;
    localparam logic [4:0] OFS_P7_DATA = 5'h18;

    // Direction register read images; port 6 direction reset value
    localparam logic [7:0] P2_DIR_IMAGE = 8'hFC;
    localparam logic [7:0] P3_DIR_IMAGE = 8'hFE;
    localparam logic [7:0] P6_DIR_RESET = 8'h00;

    // Field positions in the RAM/port-5 control register
    localparam int CTRL_IRQ_A_BIT = 0;
    localparam int CTRL_IRQ_B_BIT = 1;
    localparam int CTRL_MRE_BIT = 2;
    localparam int CTRL_HALT_BIT = 3;
    localparam int CTRL_RAM_BIT = 6;
    localparam int CTRL_STBY_BIT = 7;
    // Bits 6..0 reset; bits 4,5 read one
    localparam logic [6:0] CTRL_RESET = 7'h7C;
    localparam logic [6:0] CTRL_UNUSED_ONES = 7'h30;

    // Port 7 width, upper read bits
    localparam int P7_WIDTH = 5;
    localparam logic [2:0] P7_UPPER_ONES = 3'h7;

    // Value returned for unmapped offsets
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // External space in KB
    localparam int EXT_SPACE_MODE1_KB = 65;
    localparam int EXT_SPACE_MODE2_KB = 61;

    // Latched operating modes
    typedef enum logic [1:0] {
        MODE_EXP_ROM_OFF,
        MODE_EXP_ROM_ON,
        MODE_SINGLE
    } iop_mode_type;

endpackage

// ### hw/iop_first_write.sv
// Float until first write
module iop_first_write (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write of the owning data register
    input wire logic wr_i,
    // Pins are driven when high
    output logic drive_o
);

    typedef struct packed {
        logic driving;
    } iop_fw_state_type;

    iop_fw_state_type state_ff;
    iop_fw_state_type nxt_state;

    // Only reset clears it
    always_comb begin
        nxt_state = state_ff;
        if (wr_i) begin
            nxt_state.driving = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign drive_o = state_ff.driving;

endmodule

// ### hw/iop_port_read.sv
// Read-back: data on outputs, pin on inputs
module iop_port_read #(
    parameter int WIDTH = 8
) (
    // One means output
    input wire logic [WIDTH-1:0] dir_i,
    // Data and pins
    input wire logic [WIDTH-1:0] data_i,
    input wire logic [WIDTH-1:0] pin_i,
    // Value seen by software
    output logic [WIDTH-1:0] value_o
);

    // Pure selection, no state
    always_comb begin
        value_o = (dir_i & data_i) | (~dir_i & pin_i);
    end

endmodule

// ### hw/iop_ports.sv
// Operation
// - Mode 3: port 1 floats until written
// - First port 1 write drives; readable register
// - Modes 1,2: port 1 drives address low
// - Port 2 direction: bit0 pin0, bit1 rest
// - Peripheral use overrides port 2 direction
// - Reset clears port 2 direction, image FC
// - Port 3 one direction bit, image FE
// - Port 4 output only; high address
// - Port 5 input only; feeds irq, ready, halt
// - Port 6 per-pin direction, reset 00
// - Mode 3: port 7 floats until written
// - Port 7 reads data, upper three ones
// - Modes 1,2: port 7 carries bus control
// - Control bits 0,1 gate external interrupts
// - Bit 2 memory ready, off in mode 3
// - Bit 3 halt enable, off in mode 3
// - Bit 6 on-chip RAM enable, set at reset
// - Bit 7 flag cleared on standby power loss
// - Mode pins select modes 1, 2, 3
// - Mode 1: data bus, ROM off, external vectors
// - Mode 2: data bus, ROM on
// - Mode latched during reset, held after
//
// Decided for this implementation: strobed register access.
module iop_ports (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Mode pins
    input wire logic mode_pin_low_i,
    input wire logic mode_pin_high_i,
    // Expanded-mode bus from the CPU
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_data_drive_i,
    input wire logic bus_float_i,
    input wire logic bus_rd_n_i,
    input wire logic bus_wr_n_i,
    input wire logic bus_rw_i,
    input wire logic opcode_fetch_strobe_n_i,
    input wire logic bus_released_i,
    output logic [7:0] bus_rdata_o,
    // Peripheral use of port 2
    input wire logic [7:1] periph_p2_sel_i,
    input wire logic [7:1] periph_p2_dir_i,
    input wire logic [7:1] periph_p2_out_i,
    output logic [7:0] periph_p2_in_o,
    // Standby supply monitor
    input wire logic standby_power_lost_i,
    // Port 1 pins
    output logic [7:0] p1_out_o,
    output logic [7:0] p1_oe_n_o,
    // Port 2 pins
    input wire logic [7:0] p2_in_i,
    output logic [7:0] p2_out_o,
    output logic [7:0] p2_oe_n_o,
    // Port 3 pins
    input wire logic [7:0] p3_in_i,
    output logic [7:0] p3_out_o,
    output logic [7:0] p3_oe_n_o,
    // Port 4 pins
    output logic [7:0] p4_out_o,
    output logic [7:0] p4_oe_n_o,
    // Port 5 pins
    input wire logic [7:0] p5_in_i,
    // Port 6 pins
    input wire logic [7:0] p6_in_i,
    output logic [7:0] p6_out_o,
    output logic [7:0] p6_oe_n_o,
    // Port 7 pins
    output logic [4:0] p7_out_o,
    output logic [4:0] p7_oe_n_o,
    // Port 5 alternate functions
    output logic ext_interrupt_a_req_o,
    output logic ext_interrupt_b_req_o,
    output logic memory_ready_input_o,
    output logic mem_ready_active_o,
    output logic halt_req_o,
    // Memory map and mode status
    output logic onchip_ram_enable_o,
    output logic rom_enable_o,
    output logic vectors_external_o,
    output logic expanded_mode_o,
    output logic [6:0] ext_space_kb_o
);

    // All state except the first-write latches
    typedef struct packed {
        iop_pkg::iop_mode_type mode;
        logic [1:0] p2_dir;
        logic p3_dir;
        logic [7:0] p6_dir;
        logic [7:0] p1_data;
        logic [7:0] p2_data;
        logic [7:0] p3_data;
        logic [7:0] p4_data;
        logic [7:0] p6_data;
        logic [4:0] p7_data;
        logic [6:0] ctrl;
        logic stby_flag;
        logic [7:0] rdata;
        logic [7:0] bus_rdata;
        logic [7:0] p1_out;
        logic [7:0] p1_oe_n;
        logic [7:0] p2_out;
        logic [7:0] p2_oe_n;
        logic [7:0] p3_out;
        logic [7:0] p3_oe_n;
        logic [7:0] p4_out;
        logic [7:0] p4_oe_n;
        logic [7:0] p6_out;
        logic [7:0] p6_oe_n;
        logic [4:0] p7_out;
        logic [4:0] p7_oe_n;
        logic [3:0] alt_fn;
    } iop_state_type;

    iop_state_type state_ff;
    iop_state_type nxt_state;

    // Write decodes
    logic wr_p1;
    logic wr_p7;
    // First-write latches
    logic p1_drive;
    logic p7_drive;
    // Effective per-pin directions
    logic [7:0] p2_dir_pins;
    logic [7:0] p3_dir_pins;
    // Software read-back values
    logic [7:0] p2_value;
    logic [7:0] p3_value;
    logic [7:0] p6_value;
    // Decoded mode pins
    iop_pkg::iop_mode_type pin_mode;
    logic single_chip;

    assign wr_p1 = wr_i && (addr_i == iop_pkg::OFS_P1_DATA);
    assign wr_p7 = wr_i && (addr_i == iop_pkg::OFS_P7_DATA);

    // Ports 1 and 7 float in mode 3 until written
    iop_first_write u_p1_fw (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_p1),
        .drive_o(p1_drive)
    );

    iop_first_write u_p7_fw (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_p7),
        .drive_o(p7_drive)
    );

    // Peripherals take over pins 1..7
    always_comb begin
        p2_dir_pins[0] = state_ff.p2_dir[0];
        for (int i = 1; i < 8; i++) begin
            p2_dir_pins[i] = periph_p2_sel_i[i] ? periph_p2_dir_i[i] : state_ff.p2_dir[1];
        end
    end

    // One bit for all of port 3
    assign p3_dir_pins = {8{state_ff.p3_dir}};

    iop_port_read #(.WIDTH(8)) u_p2_rd (
        .dir_i(p2_dir_pins),
        .data_i(state_ff.p2_data),
        .pin_i(p2_in_i),
        .value_o(p2_value)
    );

    iop_port_read #(.WIDTH(8)) u_p3_rd (
        .dir_i(p3_dir_pins),
        .data_i(state_ff.p3_data),
        .pin_i(p3_in_i),
        .value_o(p3_value)
    );

    iop_port_read #(.WIDTH(8)) u_p6_rd (
        .dir_i(state_ff.p6_dir),
        .data_i(state_ff.p6_data),
        .pin_i(p6_in_i),
        .value_o(p6_value)
    );

    // Unlisted low/low code acts as mode 3
    always_comb begin
        if (mode_pin_low_i && !mode_pin_high_i) begin
            pin_mode = iop_pkg::MODE_EXP_ROM_OFF;
        end else if (!mode_pin_low_i && mode_pin_high_i) begin
            pin_mode = iop_pkg::MODE_EXP_ROM_ON;
        end else begin
            pin_mode = iop_pkg::MODE_SINGLE;
        end
    end

    assign single_chip = (state_ff.mode == iop_pkg::MODE_SINGLE);

    // Next-state logic
    always_comb begin
        nxt_state = state_ff;

        // Writes; port 5 and holes ignored
        if (wr_i) begin
            unique case (addr_i)
                iop_pkg::OFS_P2_DIR: nxt_state.p2_dir = wdata_i[1:0];
                iop_pkg::OFS_P1_DATA: nxt_state.p1_data = wdata_i;
                iop_pkg::OFS_P2_DATA: nxt_state.p2_data = wdata_i;
                iop_pkg::OFS_P3_DIR: nxt_state.p3_dir = wdata_i[0];
                iop_pkg::OFS_P3_DATA: nxt_state.p3_data = wdata_i;
                iop_pkg::OFS_P4_DATA: nxt_state.p4_data = wdata_i;
                iop_pkg::OFS_CTRL: begin
                    nxt_state.ctrl = wdata_i[6:0] | iop_pkg::CTRL_UNUSED_ONES;
                    nxt_state.stby_flag = wdata_i[iop_pkg::CTRL_STBY_BIT];
                end
                iop_pkg::OFS_P6_DIR: nxt_state.p6_dir = wdata_i;
                iop_pkg::OFS_P6_DATA: nxt_state.p6_data = wdata_i;
                iop_pkg::OFS_P7_DATA: nxt_state.p7_data = wdata_i[4:0];
                default: begin
                    // Port 5 and holes: no effect
                    nxt_state.p2_dir = state_ff.p2_dir;
                end
            endcase
        end

        // Power loss beats a same-cycle write
        if (standby_power_lost_i) begin
            nxt_state.stby_flag = 1'b0;
        end

        // Read data for one cycle
        nxt_state.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                iop_pkg::OFS_P2_DIR: nxt_state.rdata = iop_pkg::P2_DIR_IMAGE | {6'h00, state_ff.p2_dir};
                iop_pkg::OFS_P1_DATA: nxt_state.rdata = state_ff.p1_data;
                iop_pkg::OFS_P2_DATA: nxt_state.rdata = p2_value;
                iop_pkg::OFS_P3_DIR: nxt_state.rdata = iop_pkg::P3_DIR_IMAGE | {7'h00, state_ff.p3_dir};
                iop_pkg::OFS_P3_DATA: nxt_state.rdata = p3_value;
                iop_pkg::OFS_P4_DATA: nxt_state.rdata = state_ff.p4_data;
                iop_pkg::OFS_CTRL: nxt_state.rdata = {state_ff.stby_flag, state_ff.ctrl};
                iop_pkg::OFS_P5_IN: nxt_state.rdata = p5_in_i;
                iop_pkg::OFS_P6_DIR: nxt_state.rdata = state_ff.p6_dir;
                iop_pkg::OFS_P6_DATA: nxt_state.rdata = p6_value;
                iop_pkg::OFS_P7_DATA: nxt_state.rdata = {iop_pkg::P7_UPPER_ONES, state_ff.p7_data};
                default: nxt_state.rdata = iop_pkg::UNMAPPED_READ;
            endcase
        end

        // Port 2: peripheral or data register
        for (int i = 0; i < 8; i++) begin
            if (i > 0 && periph_p2_sel_i[i]) begin
                nxt_state.p2_out[i] = periph_p2_out_i[i];
            end else begin
                nxt_state.p2_out[i] = state_ff.p2_data[i];
            end
        end
        nxt_state.p2_oe_n = ~p2_dir_pins;

        // Port 6
        nxt_state.p6_out = state_ff.p6_data;
        nxt_state.p6_oe_n = ~state_ff.p6_dir;

        // Data bus capture
        nxt_state.bus_rdata = p3_in_i;

        if (single_chip) begin
            // General ports
            nxt_state.p1_out = state_ff.p1_data;
            nxt_state.p1_oe_n = {8{~p1_drive}};
            nxt_state.p3_out = state_ff.p3_data;
            nxt_state.p3_oe_n = ~p3_dir_pins;
            nxt_state.p4_out = state_ff.p4_data;
            nxt_state.p4_oe_n = 8'h00;
            nxt_state.p7_out = state_ff.p7_data;
            nxt_state.p7_oe_n = {iop_pkg::P7_WIDTH{~p7_drive}};
        end else begin
            // Buses; a halt releases them
            nxt_state.p1_out = bus_addr_i[7:0];
            nxt_state.p1_oe_n = {8{bus_float_i}};
            nxt_state.p4_out = bus_addr_i[15:8];
            nxt_state.p4_oe_n = {8{bus_float_i}};
            nxt_state.p3_out = bus_wdata_i;
            nxt_state.p3_oe_n = {8{~bus_data_drive_i | bus_float_i}};
            nxt_state.p7_out = {bus_released_i, opcode_fetch_strobe_n_i, bus_rw_i, bus_wr_n_i, bus_rd_n_i};
            // Fetch and bus-released bits stay driven
            nxt_state.p7_oe_n = {2'b00, {3{bus_float_i}}};
        end

        // Port 5 functions, pins active low
        nxt_state.alt_fn[0] = state_ff.ctrl[iop_pkg::CTRL_IRQ_A_BIT] & ~p5_in_i[0];
        nxt_state.alt_fn[1] = state_ff.ctrl[iop_pkg::CTRL_IRQ_B_BIT] & ~p5_in_i[1];
        // Live after reset until cleared; off in mode 3
        nxt_state.alt_fn[2] = state_ff.ctrl[iop_pkg::CTRL_MRE_BIT] & ~single_chip;
        nxt_state.alt_fn[3] = state_ff.ctrl[iop_pkg::CTRL_HALT_BIT] & ~single_chip & ~p5_in_i[3];
    end

    // State register; mode follows pins in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= '0;
            state_ff.mode <= pin_mode;
            state_ff.p2_dir <= '0;
            state_ff.p3_dir <= 1'b0;
            state_ff.p6_dir <= iop_pkg::P6_DIR_RESET;
            state_ff.ctrl <= iop_pkg::CTRL_RESET;
            // Standby flag survives reset
            state_ff.stby_flag <= state_ff.stby_flag & ~standby_power_lost_i;
            state_ff.p1_oe_n <= 8'hFF;
            state_ff.p2_oe_n <= 8'hFF;
            state_ff.p3_oe_n <= 8'hFF;
            state_ff.p4_oe_n <= 8'hFF;
            state_ff.p6_oe_n <= 8'hFF;
            state_ff.p7_oe_n <= 5'h1F;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Registered outputs, except periph_p2_in_o and memory_ready_input_o, which pass pins through
    assign rdata_o = state_ff.rdata;
    assign bus_rdata_o = state_ff.bus_rdata;
    assign periph_p2_in_o = p2_in_i;
    assign p1_out_o = state_ff.p1_out;
    assign p1_oe_n_o = state_ff.p1_oe_n;
    assign p2_out_o = state_ff.p2_out;
    assign p2_oe_n_o = state_ff.p2_oe_n;
    assign p3_out_o = state_ff.p3_out;
    assign p3_oe_n_o = state_ff.p3_oe_n;
    assign p4_out_o = state_ff.p4_out;
    assign p4_oe_n_o = state_ff.p4_oe_n;
    assign p6_out_o = state_ff.p6_out;
    assign p6_oe_n_o = state_ff.p6_oe_n;
    assign p7_out_o = state_ff.p7_out;
    assign p7_oe_n_o = state_ff.p7_oe_n;
    assign ext_interrupt_a_req_o = state_ff.alt_fn[0];
    assign ext_interrupt_b_req_o = state_ff.alt_fn[1];
    assign mem_ready_active_o = state_ff.alt_fn[2];
    assign memory_ready_input_o = p5_in_i[2];
    assign halt_req_o = state_ff.alt_fn[3];

    // Memory map status
    assign onchip_ram_enable_o = state_ff.ctrl[iop_pkg::CTRL_RAM_BIT];
    assign rom_enable_o = (state_ff.mode != iop_pkg::MODE_EXP_ROM_OFF);
    assign vectors_external_o = (state_ff.mode == iop_pkg::MODE_EXP_ROM_OFF);
    assign expanded_mode_o = ~single_chip;
    assign ext_space_kb_o = (state_ff.mode == iop_pkg::MODE_EXP_ROM_OFF) ? 7'(iop_pkg::EXT_SPACE_MODE1_KB) :
                            (state_ff.mode == iop_pkg::MODE_EXP_ROM_ON) ? 7'(iop_pkg::EXT_SPACE_MODE2_KB) :
                            7'h00;

endmodule

// ### tb/iop_props.sv
// Port-level checks
module iop_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // External bus and pins
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_float_i,
    input wire logic [7:0] p5_in_i,
    input wire logic [7:0] p1_out_o,
    input wire logic [7:0] p1_oe_n_o,
    input wire logic [7:0] p4_out_o,
    input wire logic [4:0] p7_oe_n_o,
    // Status toward the CPU
    input wire logic ext_interrupt_a_req_o,
    input wire logic mem_ready_active_o,
    input wire logic halt_req_o,
    input wire logic rom_enable_o,
    input wire logic vectors_external_o,
    input wire logic expanded_mode_o,
    input wire logic [6:0] ext_space_kb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain; reset masks every check
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write aimed at port 1 data
    wire logic p1_wr = wr_i && addr_i == iop_pkg::OFS_P1_DATA;

    AST_RST_FLOAT: assert property ($fell(rst_i) |-> p1_oe_n_o == 8'hFF && p7_oe_n_o == 5'h1F)
        else $error("ports drove in reset");
    AST_P1_HOLD: assert property (!expanded_mode_o && $fell(p1_oe_n_o[0]) |-> $past(p1_wr, 2))
        else $error("p1 drove unwritten");
    AST_P1_DRIVE: assert property (p1_wr && !expanded_mode_o |-> ##2 p1_oe_n_o == 8'h00 && p1_out_o == $past(wdata_i, 2))
        else $error("p1 not driven");
    // Reset values linger one cycle
    AST_ADDR_OUT: assert property (expanded_mode_o && !$past(rst_i) && !$past(bus_float_i)
        |-> p1_out_o == $past(bus_addr_i[7:0]) && p4_out_o == $past(bus_addr_i[15:8]))
        else $error("address lines wrong");
    AST_P7_UPPER: assert property (rd_i && addr_i == iop_pkg::OFS_P7_DATA |=> rdata_o[7:5] == 3'h7)
        else $error("p7 upper bits");
    AST_P2_IMAGE: assert property (rd_i && addr_i == iop_pkg::OFS_P2_DIR |=> rdata_o[7:2] == 6'h3F)
        else $error("p2 dir image");
    AST_P3_IMAGE: assert property (rd_i && addr_i == iop_pkg::OFS_P3_DIR |=> rdata_o[7:1] == 7'h7F)
        else $error("p3 dir image");
    AST_NO_WAIT: assert property (!expanded_mode_o |-> !mem_ready_active_o && !halt_req_o)
        else $error("ready/halt in mode 3");
    AST_IRQ_PIN: assert property (ext_interrupt_a_req_o |-> !$past(p5_in_i[0]))
        else $error("irq without pin");
    AST_MODE_MAP: assert property (expanded_mode_o |-> (rom_enable_o ? ext_space_kb_o == 7'd61 && !vectors_external_o
        : ext_space_kb_o == 7'd65 && vectors_external_o))
        else $error("mode map");
    AST_MODE_HELD: assert property (!$past(rst_i) |-> $stable(expanded_mode_o) && $stable(rom_enable_o))
        else $error("mode changed");
    // Main scenarios reached
    cover property (p1_wr ##2 p1_oe_n_o == 8'h00);
    cover property (expanded_mode_o && !rom_enable_o);
    cover property (ext_interrupt_a_req_o);
endmodule

// ### tb/iop_pin_model.sv
// Board side of the two-way ports
module iop_pin_model (
    // Device drive per port
    input wire logic [7:0] p2_out_i,
    input wire logic [7:0] p2_oe_n_i,
    input wire logic [7:0] p3_out_i,
    input wire logic [7:0] p3_oe_n_i,
    input wire logic [7:0] p6_out_i,
    input wire logic [7:0] p6_oe_n_i,
    // Board drivers, seen wherever the device lets go
    input wire logic [7:0] p2_ext_i,
    input wire logic [7:0] p3_ext_i,
    input wire logic [7:0] p6_ext_i,
    // Resolved pin levels
    output logic [7:0] p2_pin_o,
    output logic [7:0] p3_pin_o,
    output logic [7:0] p6_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driving device wins; a released pin shows the board level, never a stale copy
    assign p2_pin_o = (p2_out_i & ~p2_oe_n_i) | (p2_ext_i & p2_oe_n_i);
    assign p3_pin_o = (p3_out_i & ~p3_oe_n_i) | (p3_ext_i & p3_oe_n_i);
    assign p6_pin_o = (p6_out_i & ~p6_oe_n_i) | (p6_ext_i & p6_oe_n_i);
endmodule

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Design inputs
    logic clk_i, rst_i, wr_i, rd_i, mode_pin_low_i, mode_pin_high_i, bus_data_drive_i, bus_float_i;
    logic bus_rd_n_i, bus_wr_n_i, bus_rw_i, opcode_fetch_strobe_n_i, bus_released_i, standby_power_lost_i;
    logic [4:0] addr_i;
    logic [7:0] wdata_i, bus_wdata_i, p5_in_i, ext2, ext3, ext6, p2_in_i, p3_in_i, p6_in_i;
    logic [15:0] bus_addr_i;
    logic [7:1] periph_p2_sel_i, periph_p2_dir_i, periph_p2_out_i;
    // Design outputs
    logic [7:0] rdata_o, bus_rdata_o, periph_p2_in_o, p1_out_o, p1_oe_n_o, p2_out_o, p2_oe_n_o;
    logic [7:0] p3_out_o, p3_oe_n_o, p4_out_o, p4_oe_n_o, p6_out_o, p6_oe_n_o;
    logic [4:0] p7_out_o, p7_oe_n_o;
    logic ext_interrupt_a_req_o, ext_interrupt_b_req_o, memory_ready_input_o, mem_ready_active_o, halt_req_o;
    logic onchip_ram_enable_o, rom_enable_o, vectors_external_o, expanded_mode_o;
    logic [6:0] ext_space_kb_o;
    // Bench state
    logic [7:0] exp_q[$];
    logic [7:0] v, d, p5v;
    logic [15:0] a16;
    logic [4:0] c5;
    logic [7:1] pd, po;
    logic rd_q;
    int seed, n_errors, num_checks, cycles;

    iop_ports i_iop_ports (.*);
    iop_pin_model i_iop_pin_model (.p2_out_i(p2_out_o), .p2_oe_n_i(p2_oe_n_o), .p3_out_i(p3_out_o),
        .p3_oe_n_i(p3_oe_n_o), .p6_out_i(p6_out_o), .p6_oe_n_i(p6_oe_n_o), .p2_ext_i(ext2), .p3_ext_i(ext3),
        .p6_ext_i(ext6), .p2_pin_o(p2_in_i), .p3_pin_o(p3_in_i), .p6_pin_o(p6_in_i));

    // 8 ns clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // One write strobe cycle
    task automatic wr(input logic [4:0] a, input logic [7:0] x);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // One read strobe cycle
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // n edges, then sample at negedge
    task automatic st(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Mode pins latch in reset
    task automatic do_reset(input logic lo, input logic hi);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode_pin_low_i <= lo;
        mode_pin_high_i <= hi;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        st(1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read data stands one cycle
    always @(posedge clk_i) begin
        if (rd_q) begin
            chk("rdata", exp_q.pop_front(), rdata_o);
        end
        rd_q <= rd_i;
    end
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        seed = 96;
        {rst_i, standby_power_lost_i, rd_q} = 3'h6;
        {wr_i, rd_i, bus_data_drive_i, bus_float_i, bus_rd_n_i, bus_wr_n_i, bus_rw_i} = 7'h00;
        {opcode_fetch_strobe_n_i, bus_released_i, mode_pin_low_i, mode_pin_high_i} = 4'h0;
        {addr_i, wdata_i, bus_wdata_i, bus_addr_i, p5_in_i} = '0;
        {periph_p2_sel_i, periph_p2_dir_i, periph_p2_out_i} = '0;
        ext2 = 8'($random(seed));
        ext3 = 8'($random(seed));
        ext6 = 8'($random(seed));
        // Mode 3; power loss clears standby flag
        do_reset(1'b1, 1'b1);
        standby_power_lost_i <= 1'b0;
        chk("p1_oe", 8'hFF, p1_oe_n_o);
        chk("p7_oe", 8'h1F, {3'h0, p7_oe_n_o});
        chk("p4_oe", 8'h00, p4_oe_n_o);
        chk("dir_oe", 8'hFF, p2_oe_n_o & p3_oe_n_o & p6_oe_n_o);
        chk("mode", 8'h01, {6'h0, expanded_mode_o, rom_enable_o});
        rd(iop_pkg::OFS_P2_DIR, 8'hFC);
        rd(iop_pkg::OFS_P3_DIR, 8'hFE);
        rd(iop_pkg::OFS_P6_DIR, 8'h00);
        rd(iop_pkg::OFS_CTRL, 8'h7C);
        st(3);
        chk("p1_oe", 8'hFF, p1_oe_n_o);
        // First writes drive
        v = 8'($random(seed));
        wr(iop_pkg::OFS_P1_DATA, v);
        wr(iop_pkg::OFS_P7_DATA, ~v);
        st(1);
        chk("p1_out", v, p1_out_o);
        chk("p1_oe", 8'h00, p1_oe_n_o);
        chk("p7_out", {3'h0, ~v[4:0]}, {3'h0, p7_out_o});
        chk("p7_oe", 8'h00, {3'h0, p7_oe_n_o});
        rd(iop_pkg::OFS_P1_DATA, v);
        rd(iop_pkg::OFS_P7_DATA, {3'h7, ~v[4:0]});
        // Port 2 split direction, peripheral override
        wr(iop_pkg::OFS_P2_DATA, v);
        wr(iop_pkg::OFS_P2_DIR, 8'h01);
        st(1);
        chk("p2_oe", 8'hFE, p2_oe_n_o);
        rd(iop_pkg::OFS_P2_DATA, {ext2[7:1], v[0]});
        rd(iop_pkg::OFS_P2_DIR, 8'hFD);
        wr(iop_pkg::OFS_P2_DIR, 8'h02);
        st(1);
        chk("p2_oe", 8'h01, p2_oe_n_o);
        chk("p2_in", {v[7:1], ext2[0]}, periph_p2_in_o);
        rd(iop_pkg::OFS_P2_DATA, {v[7:1], ext2[0]});
        pd = 7'($random(seed));
        po = 7'($random(seed));
        @(posedge clk_i);
        periph_p2_sel_i <= 7'h7F;
        periph_p2_dir_i <= pd;
        periph_p2_out_i <= po;
        st(1);
        chk("p2_oe", {~pd, 1'b1}, p2_oe_n_o);
        chk("p2_out", {po & pd, 1'b0}, {p2_out_o[7:1] & pd, 1'b0});
        @(posedge clk_i);
        periph_p2_sel_i <= 7'h00;
        // Port 3
        wr(iop_pkg::OFS_P3_DATA, ~v);
        wr(iop_pkg::OFS_P3_DIR, 8'h01);
        st(1);
        chk("p3_oe", 8'h00, p3_oe_n_o);
        rd(iop_pkg::OFS_P3_DATA, ~v);
        wr(iop_pkg::OFS_P3_DIR, 8'h00);
        rd(iop_pkg::OFS_P3_DATA, ext3);
        // Port 6
        d = 8'($random(seed));
        wr(iop_pkg::OFS_P6_DATA, v);
        wr(iop_pkg::OFS_P6_DIR, d);
        st(1);
        chk("p6_oe", ~d, p6_oe_n_o);
        rd(iop_pkg::OFS_P6_DATA, (v & d) | (ext6 & ~d));
        rd(iop_pkg::OFS_P6_DIR, d);
        // Port 5; irq A and halt pins low
        p5v = 8'($random(seed)) & 8'hF6;
        @(posedge clk_i);
        p5_in_i <= p5v;
        wr(iop_pkg::OFS_P5_IN, ~p5v);
        rd(iop_pkg::OFS_P5_IN, p5v);
        wr(iop_pkg::OFS_CTRL, 8'h01);
        st(1);
        chk("irq_a", 8'h01, {7'h0, ext_interrupt_a_req_o});
        wr(iop_pkg::OFS_CTRL, 8'h8E);
        st(1);
        chk("p5_alt", {5'h0, ~p5v[1], p5v[2], 1'b0}, {5'h0, ext_interrupt_b_req_o, memory_ready_input_o, ext_interrupt_a_req_o});
        chk("wait", 8'h00, {6'h0, mem_ready_active_o, halt_req_o});
        chk("ram_en", 8'h00, {7'h0, onchip_ram_enable_o});
        rd(iop_pkg::OFS_CTRL, 8'hBE);
        @(posedge clk_i);
        standby_power_lost_i <= 1'b1;
        @(posedge clk_i);
        standby_power_lost_i <= 1'b0;
        rd(iop_pkg::OFS_CTRL, 8'h3E);
        rd(5'h05, iop_pkg::UNMAPPED_READ);
        // Mode 1
        do_reset(1'b1, 1'b0);
        chk("space", 8'd65, {1'b0, ext_space_kb_o});
        chk("rom", 8'h02, {6'h0, vectors_external_o, rom_enable_o});
        chk("wait", 8'h03, {6'h0, mem_ready_active_o, halt_req_o});
        a16 = 16'($random(seed));
        c5 = 5'($random(seed));
        @(posedge clk_i);
        bus_addr_i <= a16;
        bus_wdata_i <= v;
        bus_data_drive_i <= 1'b1;
        {bus_released_i, opcode_fetch_strobe_n_i, bus_rw_i, bus_wr_n_i, bus_rd_n_i} <= c5;
        mode_pin_high_i <= 1'b1;
        st(1);
        chk("p1_out", a16[7:0], p1_out_o);
        chk("p4_out", a16[15:8], p4_out_o);
        chk("p7_out", {3'h0, c5}, {3'h0, p7_out_o});
        chk("p3_out", v, p3_out_o & ~p3_oe_n_o);
        chk("mode", 8'h01, {7'h0, expanded_mode_o});
        @(posedge clk_i);
        bus_data_drive_i <= 1'b0;
        bus_float_i <= 1'b1;
        st(2);
        chk("bus_rdata", ext3, bus_rdata_o);
        chk("p7_oe", 8'h07, {3'h0, p7_oe_n_o});
        // Ready, halt as inputs
        wr(iop_pkg::OFS_CTRL, 8'h00);
        st(1);
        chk("wait", 8'h00, {6'h0, mem_ready_active_o, halt_req_o});
        // Mode 2
        do_reset(1'b0, 1'b1);
        chk("space", 8'd61, {1'b0, ext_space_kb_o});
        chk("rom", 8'h01, {6'h0, vectors_external_o, rom_enable_o});
        st(2);
        results();
    end
endmodule

bind iop_ports iop_props i_iop_props (.*);
